// ===== rtl/scs_regs.vh
`ifndef SCS_REGS_VH
`define SCS_REGS_VH
// Register indices
`define SCS_IDX_POWER_RESET 8'h06
`define SCS_IDX_SERIAL_CONFIG 8'h07
`define SCS_IDX_OPERATION_CONTROL 8'h09
`define SCS_IDX_INTERNAL_TWO 8'h02
`define SCS_IDX_POWER_CONTROL 8'h0A
`define SCS_IDX_POWER_STATUS 8'h0B
// Reset values
`define SCS_RST_POWER_RESET 8'h00
`define SCS_RST_SERIAL_CONFIG 8'hAA
`define SCS_RST_OPERATION_CONTROL 8'h02
`define SCS_RST_INTERNAL_TWO 8'h00
`define SCS_RST_POWER_CONTROL 8'h00
// Bus addresses chosen by the strap
`define SCS_ADDR_STRAP_LOW 7'h55
`define SCS_ADDR_STRAP_HIGH 7'h33
// Field positions
`define SCS_BIT_SENSOR_RESET 0
`define SCS_BIT_POWER_OFF 1
`define SCS_BIT_SOFT_RESET 0
`define SCS_BIT_MULTI_WRITE 0
`define SCS_BIT_READY 0
// Power-up settle time
`define SCS_READY_US 2000
`define SCS_CLK_MHZ 100
`define SCS_READY_CYCLES (`SCS_READY_US * `SCS_CLK_MHZ)
`endif

// ===== rtl/scs_sync.v
`timescale 1ns/1ps
// Two-stage synchroniser for one pin level
module scs_sync (
    // Clock and reset
    input wire core_clk_in,
    input wire nrst_in,
    // Level
    input wire pin_in,
    output reg level_out
);
reg stage_one;

always @(posedge core_clk_in) begin
    if (!nrst_in) begin
        // Track the pin in reset so the strap is valid at release
        stage_one <= pin_in;
        level_out <= stage_one;
    end else begin
        stage_one <= pin_in;
        level_out <= stage_one;
    end
end
endmodule // scs_sync

// ===== rtl/scs_serial_ctrl.v
// Operation
// R1 - Start is data falling while clock is high.
// R2 - Stop is data rising while clock is high.
// R3 - Strap low gives address 1010101, high gives 0110011, caught at reset.
// R4 - Writing the bus address field replaces the responding address.
// R5 - Acknowledge holds data low across the whole high clock phase.
// R6 - Master changes data only while clock is low, except start/stop.
// R7 - Bytes are eight bits, MSB first, each followed by acknowledge.
// R8 - Write: address+W, index, data, each acknowledged; stop or start ends.
// R9 - Read: index write, repeated start, address+R, one byte, master nacks.
// R10 - Multi-write bit allows several register writes in one transfer.
// R11 - In multi-write the index increments after each acknowledged data byte.
// R12 - Slave only: never drives the clock nor starts transfers.
// R13 - Serial clock times only the interface; all else on master clock.
// R14 - Reset at power on, reset pin low, or sensor reset bit written.
// R15 - Soft reset bit resets every timing and control state machine.
// R16 - Power down by pin high or bit; power up by pin low or bit.
// R17 - Ready status bit shows when powered up; no capture before it.
// R18 - Master writes 01 to internal two, then 82 to power control.
// R19 - Master writes 86 power control, 07 op control, 00 internal two.
// R20 - No acknowledge when the received address does not match.
// R21 - Power/reset register sits at index 06h and resets to 00h.
//
// The plain strobed port and the register offsets other than the power/reset index [R21] are this design's own decisions.
`timescale 1ns/1ps
`include "scs_regs.vh"
module scs_serial_ctrl #(
    parameter READY_CYCLES = `SCS_READY_CYCLES
) (
    // Clock and reset
    input wire core_clk_in,
    input wire nrst_in,
    // Serial pins
    input wire scl_in,
    input wire sda_in,
    output reg sda_out,
    output reg sda_oe_out,
    // Straps and control pins
    input wire addr_sel_in,
    input wire reset_pin_n_in,
    input wire power_down_pin_in,
    // Local register port
    input wire [7:0] addr_in,
    input wire [7:0] wdata_in,
    input wire wr_in,
    input wire rd_in,
    output reg [7:0] rdata_out,
    // Sensor control
    output reg sensor_reset_out,
    output reg seq_reset_out,
    output reg powered_down_out,
    output reg ready_out,
    output reg capture_allow_out
);

////////////////////////////////////////////////////////////////////////
// Pin synchronisers; serial clock is only sampled, never a clock [R13]
wire scl_s;
wire sda_s;
wire sel_s;
wire rstp_s;
wire pdp_s;

scs_sync u_sync_scl (.core_clk_in(core_clk_in), .nrst_in(nrst_in),
    .pin_in(scl_in), .level_out(scl_s));
scs_sync u_sync_sda (.core_clk_in(core_clk_in), .nrst_in(nrst_in),
    .pin_in(sda_in), .level_out(sda_s));
scs_sync u_sync_sel (.core_clk_in(core_clk_in), .nrst_in(nrst_in),
    .pin_in(addr_sel_in), .level_out(sel_s));
scs_sync u_sync_rst (.core_clk_in(core_clk_in), .nrst_in(nrst_in),
    .pin_in(reset_pin_n_in), .level_out(rstp_s));
scs_sync u_sync_pd (.core_clk_in(core_clk_in), .nrst_in(nrst_in),
    .pin_in(power_down_pin_in), .level_out(pdp_s));

reg scl_d;
reg sda_d;
wire scl_rise = scl_s & ~scl_d;
wire scl_fall = ~scl_s & scl_d;
wire start_det = scl_s & scl_d & sda_d & ~sda_s; // [R1]
wire stop_det = scl_s & scl_d & ~sda_d & sda_s; // [R2]

////////////////////////////////////////////////////////////////////////
// Registers
reg [7:0] power_reset_reg;
reg [7:0] serial_config_reg;
reg [7:0] operation_control_reg;
reg [7:0] internal_reg_two;
reg [7:0] power_control_reg;
reg strap_taken;
wire [6:0] bus_address_field = serial_config_reg[7:1];
wire multi_write_enable = serial_config_reg[`SCS_BIT_MULTI_WRITE];
wire power_off_bit = power_reset_reg[`SCS_BIT_POWER_OFF];

// Serial write request into the register file
reg ser_wr;
reg [7:0] ser_idx;
reg [7:0] ser_data;

// Register read mux shared by local port and serial reads
function [7:0] reg_read;
    input [7:0] idx;
    begin
        case (idx)
            `SCS_IDX_POWER_RESET: reg_read = power_reset_reg;
            `SCS_IDX_SERIAL_CONFIG: reg_read = serial_config_reg;
            `SCS_IDX_OPERATION_CONTROL: reg_read = operation_control_reg;
            `SCS_IDX_INTERNAL_TWO: reg_read = internal_reg_two;
            `SCS_IDX_POWER_CONTROL: reg_read = power_control_reg;
            `SCS_IDX_POWER_STATUS: reg_read = {7'h00, ready_out};
            default: reg_read = 8'h00;
        endcase
    end
endfunction

// Serial write wins over a local write in the same cycle
wire do_wr = ser_wr | wr_in;
wire [7:0] wr_idx = ser_wr ? ser_idx : addr_in;
wire [7:0] wr_val = ser_wr ? ser_data : wdata_in;
wire write_sensor_reset = do_wr && wr_idx == `SCS_IDX_POWER_RESET &&
    wr_val[`SCS_BIT_SENSOR_RESET];
wire write_soft_reset = do_wr && wr_idx == `SCS_IDX_OPERATION_CONTROL &&
    wr_val[`SCS_BIT_SOFT_RESET];

always @(posedge core_clk_in) begin
    if (!nrst_in) begin
        power_reset_reg <= `SCS_RST_POWER_RESET; // [R21]
        serial_config_reg <= `SCS_RST_SERIAL_CONFIG;
        operation_control_reg <= `SCS_RST_OPERATION_CONTROL;
        internal_reg_two <= `SCS_RST_INTERNAL_TWO;
        power_control_reg <= `SCS_RST_POWER_CONTROL;
        strap_taken <= 1'b0;
        rdata_out <= 8'h00;
    end else begin
        // Strap caught once after release, then software may override
        if (!strap_taken) begin
            strap_taken <= 1'b1;
            serial_config_reg[7:1] <= sel_s ? `SCS_ADDR_STRAP_HIGH :
                `SCS_ADDR_STRAP_LOW; // [R3]
        end
        if (do_wr) begin
            case (wr_idx)
                `SCS_IDX_POWER_RESET: power_reset_reg <= wr_val; // [R21]
                `SCS_IDX_SERIAL_CONFIG: serial_config_reg <= wr_val; // [R4]
                `SCS_IDX_OPERATION_CONTROL: operation_control_reg <= wr_val;
                `SCS_IDX_INTERNAL_TWO: internal_reg_two <= wr_val;
                `SCS_IDX_POWER_CONTROL: power_control_reg <= wr_val;
                default: ;
            endcase
        end
        // Reset bits act as strobes and do not stay set
        if (write_sensor_reset)
            power_reset_reg[`SCS_BIT_SENSOR_RESET] <= 1'b0;
        if (write_soft_reset)
            operation_control_reg[`SCS_BIT_SOFT_RESET] <= 1'b0;
        rdata_out <= rd_in ? reg_read(addr_in) : 8'h00;
    end
end

////////////////////////////////////////////////////////////////////////
// Reset, power-down and ready
reg [31:0] ready_cnt;
reg sensor_reset_pend;

always @(posedge core_clk_in) begin
    if (!nrst_in) begin
        sensor_reset_out <= 1'b1;
        seq_reset_out <= 1'b1;
        powered_down_out <= 1'b0;
        ready_out <= 1'b0;
        capture_allow_out <= 1'b0;
        ready_cnt <= 32'h00000000;
        sensor_reset_pend <= 1'b0;
    end else begin
        sensor_reset_pend <= write_sensor_reset;
        sensor_reset_out <= ~rstp_s | sensor_reset_pend; // [R14]
        seq_reset_out <= ~rstp_s | sensor_reset_pend |
            write_soft_reset; // [R15]
        powered_down_out <= pdp_s | power_off_bit; // [R16]
        if (pdp_s | power_off_bit) begin
            ready_cnt <= 32'h00000000;
            ready_out <= 1'b0;
        end else if (ready_cnt >= READY_CYCLES - 1) begin
            ready_out <= 1'b1; // [R17]
        end else begin
            ready_cnt <= ready_cnt + 32'h00000001;
        end
        capture_allow_out <= ready_out & ~(pdp_s | power_off_bit) &
            rstp_s; // [R17]
    end
end

////////////////////////////////////////////////////////////////////////
// Serial slave engine; only the data line is ever driven [R12]
localparam ST_IDLE = 6'h01;
localparam ST_ADDR = 6'h02;
localparam ST_INDEX = 6'h04;
localparam ST_DATA = 6'h08;
localparam ST_SEND = 6'h10;
localparam ST_WAITM = 6'h20;

reg [5:0] state;
reg [7:0] shift;
reg [3:0] bit_cnt;
reg in_ack;
reg ack_drive;
reg reading;
reg [7:0] tx;

always @(posedge core_clk_in) begin
    if (!nrst_in) begin
        scl_d <= 1'b1;
        sda_d <= 1'b1;
        state <= ST_IDLE;
        shift <= 8'h00;
        bit_cnt <= 4'h0;
        in_ack <= 1'b0;
        ack_drive <= 1'b0;
        reading <= 1'b0;
        tx <= 8'h00;
        ser_wr <= 1'b0;
        ser_idx <= 8'h00;
        ser_data <= 8'h00;
        sda_out <= 1'b0;
        sda_oe_out <= 1'b0;
    end else begin
        scl_d <= scl_s;
        sda_d <= sda_s;
        ser_wr <= 1'b0;
        sda_out <= 1'b0;
        if (stop_det) begin // [R8]
            state <= ST_IDLE;
            sda_oe_out <= 1'b0;
            in_ack <= 1'b0;
        end else if (start_det) begin // [R9]
            state <= ST_ADDR;
            bit_cnt <= 4'h0;
            in_ack <= 1'b0;
            sda_oe_out <= 1'b0;
        end else if (scl_rise && !in_ack && state != ST_IDLE &&
                state != ST_SEND) begin
            // Sample on rising edge; master holds data while high [R6]
            shift <= {shift[6:0], sda_s}; // [R7]
            bit_cnt <= bit_cnt + 4'h1;
        end else if (scl_rise && state == ST_SEND && in_ack) begin
            // Master acknowledge: low continues, high (nack) ends
            if (sda_s)
                state <= ST_WAITM; // [R9]
            else
                tx <= reg_read(ser_idx + 8'h01);
        end else if (scl_fall) begin
            if (in_ack) begin
                // Acknowledge slot finished; release line after low edge
                in_ack <= 1'b0;
                bit_cnt <= 4'h0;
                sda_oe_out <= 1'b0;
                if (state == ST_SEND) begin
                    ser_idx <= ser_idx + 8'h01;
                    sda_oe_out <= ~tx[7];
                    shift <= {tx[6:0], 1'b0};
                    bit_cnt <= 4'h1;
                end else if (ack_drive && reading && state != ST_WAITM) begin
                    // Master nack parks in wait; never resume sending
                    state <= ST_SEND;
                    sda_oe_out <= ~tx[7]; // [R7]
                    shift <= {tx[6:0], 1'b0};
                    bit_cnt <= 4'h1;
                end else if (!ack_drive) begin
                    state <= ST_WAITM;
                end
            end else if (state == ST_SEND) begin
                if (bit_cnt == 4'h8) begin
                    // Release for master acknowledge
                    sda_oe_out <= 1'b0;
                    in_ack <= 1'b1;
                end else begin
                    sda_oe_out <= ~shift[7];
                    shift <= {shift[6:0], 1'b0};
                    bit_cnt <= bit_cnt + 4'h1;
                end
            end else if (bit_cnt == 4'h8 && state != ST_IDLE &&
                    state != ST_WAITM) begin
                // Eighth bit done: decide on acknowledge
                in_ack <= 1'b1;
                ack_drive <= 1'b0;
                case (state)
                    ST_ADDR: begin
                        if (shift[7:1] == bus_address_field) begin
                            ack_drive <= 1'b1;
                            sda_oe_out <= 1'b1; // [R5]
                            reading <= shift[0];
                            tx <= reg_read(ser_idx);
                            if (!shift[0])
                                state <= ST_INDEX;
                        end
                        // Mismatch leaves line released [R20]
                    end
                    ST_INDEX: begin
                        ser_idx <= shift;
                        ack_drive <= 1'b1;
                        sda_oe_out <= 1'b1; // [R5]
                        state <= ST_DATA;
                    end
                    default: begin
                        ack_drive <= 1'b1;
                        sda_oe_out <= 1'b1; // [R5]
                        ser_wr <= 1'b1; // [R8]
                        ser_data <= shift;
                        // Without multi-write further bytes are refused
                        if (multi_write_enable)
                            state <= ST_DATA; // [R10]
                        else
                            state <= ST_WAITM;
                    end
                endcase
            end
        end
        // Advance index once the accepted byte has been written [R11]
        if (ser_wr && multi_write_enable)
            ser_idx <= ser_idx + 8'h01; // [R11]
    end
end

endmodule // scs_serial_ctrl

// ===== tb/scs_assertions.sv
`timescale 1ns/1ps
module scs_assertions #(
    parameter READY_CYCLES = 20
) (
    // Clock and reset
    input wire core_clk_in,
    input wire nrst_in,
    // Watched ports
    input wire scl_in,
    input wire sda_in,
    input wire sda_out,
    input wire sda_oe_out,
    input wire addr_sel_in,
    input wire reset_pin_n_in,
    input wire power_down_pin_in,
    input wire [7:0] addr_in,
    input wire [7:0] wdata_in,
    input wire wr_in,
    input wire rd_in,
    input wire [7:0] rdata_out,
    input wire sensor_reset_out,
    input wire seq_reset_out,
    input wire powered_down_out,
    input wire ready_out,
    input wire capture_allow_out
);
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (!nrst_in);
    int up_cnt;
    // Saturates so a long run cannot wrap
    always @(posedge core_clk_in) begin
        if (!nrst_in || powered_down_out)
            up_cnt <= 0;
        else if (up_cnt < READY_CYCLES + 8)
            up_cnt <= up_cnt + 1;
    end
////////////////////////////////////////
    chk_ack_hold: assert property (
        scl_in && $past(scl_in) |-> $stable(sda_oe_out))
        else $error("Data drive moved while clock high");
    chk_open_drain: assert property (
        sda_oe_out |-> !sda_out)
        else $error("Data pin driven high");
    chk_idle_quiet: assert property (
        (scl_in && sda_in)[*8] |-> !sda_oe_out)
        else $error("Slave drove an idle bus");
    chk_pd_pin: assert property (
        power_down_pin_in[*5] |-> powered_down_out)
        else $error("Power-down pin ignored");
    chk_ready_down: assert property (
        powered_down_out[*2] |-> !ready_out)
        else $error("Ready while powered down");
    chk_capture_gate: assert property (
        (!ready_out || powered_down_out)[*2] |-> !capture_allow_out)
        else $error("Capture allowed before ready");
    chk_pin_reset: assert property (
        !reset_pin_n_in[*4] |-> sensor_reset_out && !capture_allow_out)
        else $error("Reset pin ignored");
    chk_seq_follow: assert property (
        sensor_reset_out[*2] |-> seq_reset_out)
        else $error("Sequencer not reset with sensor");
    chk_ready_early: assert property (
        $rose(ready_out) |-> up_cnt >= READY_CYCLES - 4)
        else $error("Ready came too early");
    cover property ($rose(sda_oe_out));
    cover property ($rose(ready_out));
    cover property ($rose(seq_reset_out));
    cover property ($rose(powered_down_out));
endmodule // scs_assertions
bind scs_serial_ctrl scs_assertions #(.READY_CYCLES(READY_CYCLES))
    i_scs_assertions (.core_clk_in(core_clk_in), .nrst_in(nrst_in),
    .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe_out(sda_oe_out), .addr_sel_in(addr_sel_in),
    .reset_pin_n_in(reset_pin_n_in),
    .power_down_pin_in(power_down_pin_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .sensor_reset_out(sensor_reset_out),
    .seq_reset_out(seq_reset_out), .powered_down_out(powered_down_out),
    .ready_out(ready_out), .capture_allow_out(capture_allow_out));

// ===== tb/scs_master.sv
`timescale 1ns/1ps
module scs_master (
    // Serial pins
    output logic scl_out,
    output logic sda_low_out,
    input logic sda_in
);
    // Clock stands high between frames
    initial begin
        scl_out = 1'b1;
        sda_low_out = 1'b0;
    end
    task automatic start();
        sda_low_out = 1'b0;
        #40 scl_out = 1'b1;
        #40 sda_low_out = 1'b1;
        #40 scl_out = 1'b0;
    endtask
    task automatic stop();
        #10 sda_low_out = 1'b1;
        #30 scl_out = 1'b1;
        #40 sda_low_out = 1'b0;
        #40;
    endtask
    // Data moves only in the low phase
    task automatic xbit(input logic b, output logic r);
        #10 sda_low_out = !b;
        #30 scl_out = 1'b1;
        #20 r = sda_in;
        #20 scl_out = 1'b0;
    endtask
    // Ninth slot returns the raw level: 1 means no acknowledge
    task automatic xbyte(input logic [7:0] d, input logic mack,
                         output logic [7:0] r, output logic nak);
        logic b;
        for (int i = 7; i >= 0; i--) begin
            xbit(d[i], b);
            r[i] = b;
        end
        xbit(mack, nak);
    endtask
endmodule // scs_master

// ===== tb/test_scs_serial_ctrl.sv
`timescale 1ns/1ps
`include "scs_regs.vh"
module test_scs_serial_ctrl;
    localparam int RDY = 20;
    logic core_clk_in, nrst_in, addr_sel_in, reset_pin_n_in;
    logic power_down_pin_in, wr_in, rd_in, rd_d;
    logic [7:0] addr_in, wdata_in, rdata_out, d;
    logic sda_out, sda_oe_out, sensor_reset_out, seq_reset_out;
    logic powered_down_out, ready_out, capture_allow_out, scl, m_low;
    logic [7:0] exp_q[$];
    logic [15:0] rnd;
    logic [3:0] ak;
    int fail_count, n_checks;
    // Pull-up: low whenever either side pulls
    wire sda = !(m_low || (sda_oe_out && !sda_out));
    scs_serial_ctrl #(.READY_CYCLES(RDY)) i_scs_serial_ctrl (
        .core_clk_in(core_clk_in), .nrst_in(nrst_in), .scl_in(scl),
        .sda_in(sda), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
        .addr_sel_in(addr_sel_in), .reset_pin_n_in(reset_pin_n_in),
        .power_down_pin_in(power_down_pin_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
        .rdata_out(rdata_out), .sensor_reset_out(sensor_reset_out),
        .seq_reset_out(seq_reset_out), .ready_out(ready_out),
        .powered_down_out(powered_down_out),
        .capture_allow_out(capture_allow_out));
    scs_master i_scs_master (.scl_out(scl), .sda_low_out(m_low),
        .sda_in(sda));
    initial begin
        core_clk_in = 1'b0;
        forever #5 core_clk_in = ~core_clk_in;
    end
////////////////////////////////////////
    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    function automatic logic pick(input int w);
        case (w)
            0: return seq_reset_out;
            1: return sensor_reset_out;
            2: return ready_out;
            default: return powered_down_out;
        endcase
    endfunction
    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wait_for(input int w, input logic v);
        int k;
        k = 0;
        while (pick(w) !== v && k < 100) begin
            @(negedge core_clk_in);
            k++;
        end
        chk8({7'h0, pick(w)}, {7'h0, v});
        if (k == 100) print_verdict();
    endtask
    task automatic lwr(input logic [7:0] a, input logic [7:0] v);
        @(posedge core_clk_in);
        wr_in <= 1'b1;
        addr_in <= a;
        wdata_in <= v;
        @(posedge core_clk_in);
        wr_in <= 1'b0;
    endtask
    task automatic lrd(input logic [7:0] a, input logic [7:0] e);
        @(posedge core_clk_in);
        rd_in <= 1'b1;
        addr_in <= a;
        exp_q.push_back(e);
        @(posedge core_clk_in);
        rd_in <= 1'b0;
        repeat (2) @(posedge core_clk_in);
    endtask
    // Read data stand in the cycle after the strobe only
    always @(posedge core_clk_in) begin
        rd_d <= rd_in;
    end
    always @(negedge core_clk_in) begin
        if (rd_d === 1'b1 && exp_q.size() > 0)
            chk8(rdata_out, exp_q.pop_front());
    end
    task automatic swr(input logic [6:0] a, input logic [7:0] i,
        input logic [7:0] d0, input logic [7:0] d1, input int n);
        logic [7:0] r;
        ak = 4'h0;
        i_scs_master.start();
        i_scs_master.xbyte({a, 1'b0}, 1'b1, r, ak[0]);
        i_scs_master.xbyte(i, 1'b1, r, ak[1]);
        i_scs_master.xbyte(d0, 1'b1, r, ak[2]);
        if (n > 1) i_scs_master.xbyte(d1, 1'b1, r, ak[3]);
        i_scs_master.stop();
    endtask
    task automatic srd(input logic [6:0] a, input logic [7:0] i);
        logic [7:0] r;
        logic x;
        ak = 4'h0;
        i_scs_master.start();
        i_scs_master.xbyte({a, 1'b0}, 1'b1, r, ak[0]);
        i_scs_master.xbyte(i, 1'b1, r, ak[1]);
        i_scs_master.start();
        i_scs_master.xbyte({a, 1'b1}, 1'b1, r, ak[2]);
        i_scs_master.xbyte(8'hFF, 1'b1, d, x);
        i_scs_master.stop();
    endtask
    task automatic do_reset(input logic strap);
        nrst_in <= 1'b0;
        addr_sel_in <= strap;
        repeat (10) @(posedge core_clk_in);
        nrst_in <= 1'b1;
        repeat (4) @(posedge core_clk_in);
    endtask
////////////////////////////////////////
    initial begin
        {nrst_in, addr_sel_in, power_down_pin_in, wr_in, rd_in} = 5'h0;
        {rd_d, addr_in, wdata_in} = 17'h0;
        reset_pin_n_in = 1'b1;
        fail_count = 0;
        n_checks = 0;
        rnd = lfsr(16'hBC9F);
        do_reset(1'b0);
        lrd(`SCS_IDX_POWER_RESET, `SCS_RST_POWER_RESET);
        lrd(`SCS_IDX_SERIAL_CONFIG, {`SCS_ADDR_STRAP_LOW, 1'b0});
        lrd(`SCS_IDX_POWER_CONTROL, `SCS_RST_POWER_CONTROL);
        lrd(8'h03, 8'h00);
        swr(`SCS_ADDR_STRAP_LOW, `SCS_IDX_INTERNAL_TWO, rnd[7:0], 8'h00, 1);
        chk8({4'h0, ak}, 8'h00);
        lrd(`SCS_IDX_INTERNAL_TWO, rnd[7:0]);
        srd(`SCS_ADDR_STRAP_LOW, `SCS_IDX_INTERNAL_TWO);
        chk8({4'h0, ak}, 8'h00);
        chk8(d, rnd[7:0]);
        swr(`SCS_ADDR_STRAP_HIGH, `SCS_IDX_INTERNAL_TWO, ~rnd[7:0], 8'h0, 1);
        chk8({4'h0, ak}, 8'h07);
        lrd(`SCS_IDX_INTERNAL_TWO, rnd[7:0]);
        swr(`SCS_ADDR_STRAP_LOW, `SCS_IDX_OPERATION_CONTROL, 8'h06, 8'h86, 2);
        chk8({4'h0, ak}, 8'h08);
        lrd(`SCS_IDX_POWER_CONTROL, 8'h00);
        lwr(`SCS_IDX_SERIAL_CONFIG, {`SCS_ADDR_STRAP_LOW, 1'b1});
        swr(`SCS_ADDR_STRAP_LOW, `SCS_IDX_OPERATION_CONTROL, 8'h06, 8'h86, 2);
        chk8({4'h0, ak}, 8'h00);
        lrd(`SCS_IDX_OPERATION_CONTROL, 8'h06);
        lrd(`SCS_IDX_POWER_CONTROL, 8'h86);
        lwr(`SCS_IDX_SERIAL_CONFIG, {`SCS_ADDR_STRAP_HIGH, 1'b0});
        rnd = lfsr(rnd);
        swr(`SCS_ADDR_STRAP_HIGH, `SCS_IDX_INTERNAL_TWO, 8'h01, 8'h00, 1);
        chk8({4'h0, ak}, 8'h00);
        swr(`SCS_ADDR_STRAP_LOW, `SCS_IDX_INTERNAL_TWO, rnd[7:0], 8'h0, 1);
        chk8({4'h0, ak}, 8'h07);
        swr(`SCS_ADDR_STRAP_HIGH, `SCS_IDX_POWER_CONTROL, 8'h82, 8'h00, 1);
        lrd(`SCS_IDX_INTERNAL_TWO, 8'h01);
        power_down_pin_in <= 1'b1;
        wait_for(3, 1'b1);
        wait_for(2, 1'b0);
        power_down_pin_in <= 1'b0;
        wait_for(3, 1'b0);
        wait_for(2, 1'b1);
        repeat (3) @(negedge core_clk_in);
        chk8({7'h0, capture_allow_out}, 8'h01);
        lrd(`SCS_IDX_POWER_STATUS, 8'h01);
        lwr(`SCS_IDX_POWER_RESET, 8'h02);
        wait_for(3, 1'b1);
        lwr(`SCS_IDX_POWER_RESET, 8'h00);
        wait_for(3, 1'b0);
        swr(`SCS_ADDR_STRAP_HIGH, `SCS_IDX_POWER_CONTROL, 8'h86, 8'h00, 1);
        swr(`SCS_ADDR_STRAP_HIGH, `SCS_IDX_INTERNAL_TWO, 8'h00, 8'h00, 1);
        chk8({4'h0, ak}, 8'h00);
        fork
            lwr(`SCS_IDX_OPERATION_CONTROL, 8'h07);
            wait_for(0, 1'b1);
        join
        lrd(`SCS_IDX_OPERATION_CONTROL, 8'h06);
        fork
            lwr(`SCS_IDX_POWER_RESET, 8'h01);
            wait_for(1, 1'b1);
        join
        lrd(`SCS_IDX_POWER_RESET, 8'h00);
        reset_pin_n_in <= 1'b0;
        wait_for(1, 1'b1);
        repeat (6) @(negedge core_clk_in);
        chk8({7'h0, capture_allow_out}, 8'h00);
        reset_pin_n_in <= 1'b1;
        wait_for(1, 1'b0);
        do_reset(1'b1);
        lrd(`SCS_IDX_SERIAL_CONFIG, {`SCS_ADDR_STRAP_HIGH, 1'b0});
        swr(`SCS_ADDR_STRAP_HIGH, `SCS_IDX_INTERNAL_TWO, rnd[15:8], 8'h0, 1);
        chk8({4'h0, ak}, 8'h00);
        print_verdict();
    end
endmodule // test_scs_serial_ctrl
